/* common/standby_restore_map.svh */
/*
  Offsets, field positions and reset values for the standby power restore control block.
  Assumes AXI4-Lite with 32-bit data and byte addressing.
*/
`ifndef STANDBY_RESTORE_MAP_SVH
`define STANDBY_RESTORE_MAP_SVH

`define SRC_CTRL_OFS      8'h00
`define SRC_STATUS_OFS    8'h04
`define SRC_IRQ_STS_OFS   8'h08
`define SRC_IRQ_CLR_OFS   8'h0C
`define SRC_IRQ_EN_OFS    8'h10
`define SRC_SLEEP_OFS     8'h14
`define SRC_EVENT_OFS     8'h18

`define SRC_BIT_STAY_OFF  1
`define SRC_BIT_PWR_ON    2
`define SRC_BIT_RET_FLAG  3
`define SRC_BIT_WAKE_GATE 4
`define SRC_BIT_REDIRECT  5
`define SRC_BIT_GO        0
`define SRC_TYPE_LSB      1
`define SRC_TYPE_W        3

`define SRC_IRQ_RETURN    0
`define SRC_IRQ_SMI       1
`define SRC_IRQ_WAKE      2
`define SRC_IRQ_W         3

`define SRC_CTRL_RST      32'h0000_0000
`define SRC_RESP_OKAY     2'h0
`define SRC_RESP_SLVERR   2'h2

`endif

/* common/standby_restore_pkg.sv */
/*
  Types for the standby power restore control block.
  Assumes the map header supplies all numbers.
*/
package standby_restore_pkg;
  typedef enum logic [1:0] {
    POLICY_RESTORE,
    POLICY_STAY_OFF,
    POLICY_POWER_ON,
    POLICY_CONFLICT
  } restore_policy_t;
endpackage : standby_restore_pkg

/* verilog/standby_power_restore_control.sv */
/*
  Standby power restore control: policy on standby return, supply-on output,
  wake flag gating, sleep request redirect, AXI4-Lite register slave.
  Assumes sys_rst_i is the standby power-on reset and ref_clk_i runs on standby power.
*/
`timescale 1ns/100ps
`include "standby_restore_map.svh"

////////////////////////////////////////////////////////////////////////////////
module standby_power_restore_control #(
  parameter int TYPE_W = `SRC_TYPE_W
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  // axi4-lite write
  input  wire logic [7:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // power system
  input  wire logic              main_power_good_i,
  input  wire logic              button_override_flag_i,
  input  wire logic              wake_event_i,
  input  wire logic              sleep_done_i,
  output logic                   supply_on_out_n_o,
  output logic                   supply_on_out_n_oe_o,
  output logic                   sleep_start_o,
  output logic [TYPE_W-1:0]      sleep_type_field_o,
  output logic                   smi_o,
  output logic                   pm_event_o,
  output logic                   wake_flag_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic                   stay_off_on_standby_return;
  logic                   power_on_on_standby_return;
  logic                   standby_return_flag;
  logic                   wake_flag_gate;
  logic                   sleep_request_redirect;
  logic [TYPE_W-1:0]      sleep_type_field;
  logic                   wake_flag;
  logic                   supply_on;
  logic                   last_power_on;
  logic                   first_cycle;
  logic [`SRC_IRQ_W-1:0]  irq_sts;
  logic [`SRC_IRQ_W-1:0]  irq_en;
  logic                   aw_held;
  logic                   w_held;
  logic [7:0]             aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  logic                   rd_fire;
  logic                   sleep_go_wr;
  logic                   sw_power_off;
  logic                   clr_return;
  logic                   clr_wake;
  logic [`SRC_IRQ_W-1:0]  irq_clr;
  logic [`SRC_IRQ_W-1:0]  irq_set;
  logic                   wr_ok;
  logic [31:0]            next_rdata;
  logic                   rd_ok;
  standby_restore_pkg::restore_policy_t policy;

  assign policy = standby_restore_pkg::restore_policy_t'(
                  {power_on_on_standby_return, stay_off_on_standby_return});

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok        = 1'b1;
    sleep_go_wr  = 1'b0;
    sw_power_off = 1'b0;
    clr_return   = 1'b0;
    clr_wake     = 1'b0;
    irq_clr      = '0;
    if (aw_addr == `SRC_CTRL_OFS) begin
      clr_return = wr_fire && w_strb[0] && w_data[`SRC_BIT_RET_FLAG];
    end else if (aw_addr == `SRC_STATUS_OFS) begin
      clr_wake = wr_fire && w_strb[0] && w_data[0];
    end else if (aw_addr == `SRC_IRQ_CLR_OFS) begin
      irq_clr = (wr_fire && w_strb[0]) ? w_data[`SRC_IRQ_W-1:0] : '0;
    end else if (aw_addr == `SRC_SLEEP_OFS) begin
      sleep_go_wr  = wr_fire && w_strb[0] && w_data[`SRC_BIT_GO];
      sw_power_off = wr_fire && w_strb[0] && w_data[7];
    end else if (aw_addr != `SRC_IRQ_EN_OFS) begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wake_flag_gate             <= 1'b0;
      sleep_request_redirect     <= 1'b0;
      sleep_type_field           <= '0;
      irq_en                     <= '0;
    end else if (wr_fire && w_strb[0]) begin
      if (aw_addr == `SRC_CTRL_OFS) begin
        wake_flag_gate             <= w_data[`SRC_BIT_WAKE_GATE];
        sleep_request_redirect     <= w_data[`SRC_BIT_REDIRECT];
      end else if (aw_addr == `SRC_SLEEP_OFS) begin
        sleep_type_field <= w_data[`SRC_TYPE_LSB +: TYPE_W];
      end else if (aw_addr == `SRC_IRQ_EN_OFS) begin
        irq_en <= w_data[`SRC_IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `SRC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= wr_ok ? `SRC_RESP_OKAY : `SRC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_ok      = 1'b1;
    if (s_axi_araddr_i == `SRC_CTRL_OFS) begin
      next_rdata[`SRC_BIT_STAY_OFF]  = stay_off_on_standby_return;
      next_rdata[`SRC_BIT_PWR_ON]    = power_on_on_standby_return;
      next_rdata[`SRC_BIT_RET_FLAG]  = standby_return_flag;
      next_rdata[`SRC_BIT_WAKE_GATE] = wake_flag_gate;
      next_rdata[`SRC_BIT_REDIRECT]  = sleep_request_redirect;
    end else if (s_axi_araddr_i == `SRC_STATUS_OFS) begin
      next_rdata[0] = wake_flag;
      next_rdata[1] = supply_on;
      next_rdata[2] = button_override_flag_i;
    end else if (s_axi_araddr_i == `SRC_IRQ_STS_OFS) begin
      next_rdata[`SRC_IRQ_W-1:0] = irq_sts;
    end else if (s_axi_araddr_i == `SRC_IRQ_EN_OFS) begin
      next_rdata[`SRC_IRQ_W-1:0] = irq_en;
    end else if (s_axi_araddr_i == `SRC_SLEEP_OFS) begin
      next_rdata[`SRC_TYPE_LSB +: TYPE_W] = sleep_type_field;
    end else if (s_axi_araddr_i != `SRC_IRQ_CLR_OFS) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= `SRC_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= next_rdata;
      s_axi_rresp_o  <= rd_ok ? `SRC_RESP_OKAY : `SRC_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby return policy
  // first cycle after reset release stands for the standby power-on event
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= 1'b0;
    end
  end

  // no reset: policy and prior state outlive the standby reset; unknown until written
  always_ff @(posedge ref_clk_i) begin
    if (!first_cycle) begin
      last_power_on <= supply_on && main_power_good_i;
    end
    if (!sys_rst_i && wr_fire && w_strb[0] && aw_addr == `SRC_CTRL_OFS) begin
      stay_off_on_standby_return <= w_data[`SRC_BIT_STAY_OFF];
      power_on_on_standby_return <= w_data[`SRC_BIT_PWR_ON];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      supply_on <= 1'b0;
    end else if (first_cycle) begin
      case (policy)
        standby_restore_pkg::POLICY_STAY_OFF:  supply_on <= 1'b0;
        standby_restore_pkg::POLICY_POWER_ON:  supply_on <= 1'b1;
        standby_restore_pkg::POLICY_RESTORE:
          supply_on <= last_power_on && !button_override_flag_i;
        default:                               supply_on <= 1'b0;
      endcase
    end else if (sw_power_off || sleep_done_i) begin
      supply_on <= 1'b0;
    end
  end

  // floats when inactive; the pin is open drain toward the supply
  assign supply_on_out_n_o    = 1'b0;
  assign supply_on_out_n_oe_o = supply_on;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      standby_return_flag <= 1'b0;
    end else if (first_cycle) begin
      standby_return_flag <= 1'b1;
    end else if (clr_return) begin
      standby_return_flag <= 1'b0;
    end
  end

  // pm event only from wake; power-up at standby return raises none
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pm_event_o <= 1'b0;
    end else begin
      pm_event_o <= wake_event_i && wake_flag_gate;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wake_flag <= 1'b0;
    end else if (wake_event_i && wake_flag_gate) begin
      wake_flag <= 1'b1;
    end else if (clr_wake) begin
      wake_flag <= 1'b0;
    end
  end
  assign wake_flag_o = wake_flag;

  ////////////////////////////////////////////////////////////////////////////
  // sleep request and redirect
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sleep_start_o      <= 1'b0;
      smi_o              <= 1'b0;
      sleep_type_field_o <= '0;
    end else begin
      sleep_start_o <= sleep_go_wr && !sleep_request_redirect;
      smi_o         <= sleep_go_wr && sleep_request_redirect;
      if (sleep_go_wr) begin
        sleep_type_field_o <= w_data[`SRC_TYPE_LSB +: TYPE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: set wins over clear
  assign irq_set[`SRC_IRQ_RETURN] = first_cycle;
  assign irq_set[`SRC_IRQ_SMI]    = smi_o;
  assign irq_set[`SRC_IRQ_WAKE]   = wake_event_i && wake_flag_gate;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      irq_sts <= '0;
    end else begin
      irq_sts <= irq_set | (irq_sts & ~irq_clr);
    end
  end
  assign irq_o = |(irq_sts & irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_stay_off;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (first_cycle && policy == standby_restore_pkg::POLICY_STAY_OFF) |=> !supply_on_out_n_oe_o;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("stay-off powered up");
  property p_power_on;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (first_cycle && policy == standby_restore_pkg::POLICY_POWER_ON) |=> supply_on_out_n_oe_o;
  endproperty
  a_power_on: assert property (p_power_on) else $error("power-on policy ignored");
  property p_restore;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (first_cycle && policy == standby_restore_pkg::POLICY_RESTORE)
      |=> supply_on == $past(last_power_on && !button_override_flag_i);
  endproperty
  a_restore: assert property (p_restore) else $error("restore state wrong");
  property p_ret_flag;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(standby_return_flag) |-> $past(first_cycle);
  endproperty
  a_ret_flag: assert property (p_ret_flag) else $error("return flag set by other");
  property p_no_event;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (first_cycle && !wake_event_i) |=> !pm_event_o;
  endproperty
  a_no_event: assert property (p_no_event) else $error("event on standby return");
  property p_wake_gate;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (!wake_flag_gate && !wake_flag) |=> !wake_flag;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake flag set while gated");
  property p_sleep;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (sleep_go_wr && !sleep_request_redirect) |=> sleep_start_o && !smi_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not started");
  property p_smi;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (sleep_go_wr && sleep_request_redirect) |=> smi_o && !sleep_start_o ##1 irq_sts[1];
  endproperty
  a_smi: assert property (p_smi) else $error("smi not raised");

endmodule : standby_power_restore_control

/* test/supply_model.sv */
/*
  Behavioural model of the external supply behind the supply-on pin.
  Assumes an open-drain active-low pin with a pull-up on the board.
*/
`timescale 1ns/100ps

module supply_model #(
  parameter int RISE_CYCLES = 4
) (
  // clock
  input  wire logic clk_i,
  // supply-on pin, split
  input  wire logic supply_on_out_n_i,
  input  wire logic supply_on_oe_i,
  // main rail status
  output logic      power_good_o
);
  logic pin_n;
  int   cnt = 0;

  // pull-up wins when nobody drives the pin
  assign pin_n = supply_on_oe_i ? supply_on_out_n_i : 1'h1;

  // the rail takes a few cycles to come up, drops at once
  always @(posedge clk_i) begin
    if (pin_n !== 1'h0) begin
      cnt          <= 0;
      power_good_o <= 1'h0;
    end else if (cnt < RISE_CYCLES) begin
      cnt <= cnt + 1;
    end else begin
      power_good_o <= 1'h1;
    end
  end
endmodule : supply_model

/* test/standby_power_restore_control_test.sv */
/*
  Self-checking bench for the standby power restore control block.
  Assumes the map header, the design and the supply model are compiled first.
*/
`timescale 1ns/100ps
`include "standby_restore_map.svh"

module standby_power_restore_control_test;
  logic        ref_clk_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        override = 1'h0, wake_ev = 1'h0, power_good, supply_n, supply_oe;
  logic        sleep_start, smi, pm_event, wake_flag, irq;
  logic [2:0]  sleep_type;
  int          n_errors = 0, comparisons = 0, n_start = 0, n_smi = 0, n_pme = 0;
  int          s0, m0, p0;

  always #2 ref_clk_i = ~ref_clk_i;

  standby_power_restore_control dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .main_power_good_i(power_good),
    .button_override_flag_i(override), .wake_event_i(wake_ev), .sleep_done_i(1'h0),
    .supply_on_out_n_o(supply_n), .supply_on_out_n_oe_o(supply_oe),
    .sleep_start_o(sleep_start), .sleep_type_field_o(sleep_type), .smi_o(smi),
    .pm_event_o(pm_event), .wake_flag_o(wake_flag), .irq_o(irq));

  supply_model supply_u (.clk_i(ref_clk_i), .supply_on_out_n_i(supply_n),
    .supply_on_oe_i(supply_oe), .power_good_o(power_good));

  // pulse counters, so one-cycle outputs are never missed
  always @(posedge ref_clk_i) begin
    if (sleep_start === 1'h1) n_start <= n_start + 1;
    if (smi === 1'h1) n_smi <= n_smi + 1;
    if (pm_event === 1'h1) n_pme <= n_pme + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic timed_out;
    n_errors++;
    $display("MISMATCH %0t handshake wait ran out", $time);
    close_out();
  endtask : timed_out

  // handshakes are judged at the rising edge; signals move only right after it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    bready <= 1'h0;
    if (n == 50) timed_out();
    else chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    @(posedge ref_clk_i);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    rready <= 1'h0;
    if (n == 50) timed_out();
    else begin
      chk(rdata & m, e, "read data");
      chk({30'h0, rresp}, {30'h0, er}, "rresp");
    end
  endtask : rd

  task automatic wake_pulse;
    @(posedge ref_clk_i);
    wake_ev <= 1'h1;
    @(posedge ref_clk_i);
    wake_ev <= 1'h0;
    repeat (3) @(posedge ref_clk_i);
  endtask : wake_pulse

  task automatic do_reset(input logic exp_on);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'h1;
    repeat (10) @(posedge ref_clk_i);
    sys_rst_i <= 1'h0;
    p0 = n_pme;
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, supply_oe}, {31'h0, exp_on}, "supply after return");
    chk({31'h0, supply_n}, 32'h0, "pin drive level");
    chk(n_pme - p0, 0, "no event on return");
    rd(`SRC_CTRL_OFS, 32'h8, 32'h8, `SRC_RESP_OKAY);
    rd(`SRC_IRQ_STS_OFS, 32'h1, 32'h1, `SRC_RESP_OKAY);
    $display("test standby return done");
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    timed_out();
  end

  initial begin
    do_reset(1'h0);
    // flag survives a zero write, goes on a one
    wr(`SRC_CTRL_OFS, 32'h0, `SRC_RESP_OKAY);
    rd(`SRC_CTRL_OFS, 32'h8, 32'h8, `SRC_RESP_OKAY);
    wr(`SRC_CTRL_OFS, 32'h8, `SRC_RESP_OKAY);
    rd(`SRC_CTRL_OFS, 32'h8, 32'h0, `SRC_RESP_OKAY);
    wr(`SRC_IRQ_CLR_OFS, 32'h1, `SRC_RESP_OKAY);
    rd(`SRC_IRQ_STS_OFS, 32'h1, 32'h0, `SRC_RESP_OKAY);
    $display("test return flag done");
    p0 = n_pme;
    wake_pulse();
    rd(`SRC_STATUS_OFS, 32'h1, 32'h0, `SRC_RESP_OKAY);
    chk(n_pme - p0, 0, "gated wake event");
    wr(`SRC_CTRL_OFS, 32'h10, `SRC_RESP_OKAY);
    wake_pulse();
    rd(`SRC_STATUS_OFS, 32'h1, 32'h1, `SRC_RESP_OKAY);
    chk({31'h0, wake_flag}, 32'h1, "wake flag");
    chk(n_pme - p0, 1, "wake event");
    wr(`SRC_IRQ_EN_OFS, 32'h4, `SRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h1, "irq on");
    wr(`SRC_IRQ_EN_OFS, 32'h0, `SRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(`SRC_IRQ_EN_OFS, 32'h4, `SRC_RESP_OKAY);
    wr(`SRC_IRQ_CLR_OFS, 32'h4, `SRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(`SRC_STATUS_OFS, 32'h1, `SRC_RESP_OKAY);
    rd(`SRC_STATUS_OFS, 32'h1, 32'h0, `SRC_RESP_OKAY);
    $display("test wake done");
    // software keeps the two policy bits apart throughout
    wr(`SRC_CTRL_OFS, 32'h0, `SRC_RESP_OKAY);
    for (int t = 0; t < 8; t++) begin
      s0 = n_start;
      m0 = n_smi;
      wr(`SRC_SLEEP_OFS, 32'(t * 2 + 1), `SRC_RESP_OKAY);
      repeat (2) @(posedge ref_clk_i);
      chk(n_start - s0, 1, "sleep start");
      chk(n_smi - m0, 0, "no smi");
      chk({29'h0, sleep_type}, 32'(t), "sleep type");
    end
    wr(`SRC_CTRL_OFS, 32'h20, `SRC_RESP_OKAY);
    s0 = n_start;
    m0 = n_smi;
    wr(`SRC_SLEEP_OFS, 32'hB, `SRC_RESP_OKAY);
    repeat (2) @(posedge ref_clk_i);
    chk(n_start - s0, 0, "redirected sleep");
    chk(n_smi - m0, 1, "smi pulse");
    rd(`SRC_IRQ_STS_OFS, 32'h2, 32'h2, `SRC_RESP_OKAY);
    $display("test sleep done");
    override <= 1'h1;
    rd(`SRC_STATUS_OFS, 32'h4, 32'h4, `SRC_RESP_OKAY);
    wr(8'h40, 32'hFF, `SRC_RESP_SLVERR);
    rd(8'h40, 32'hFFFF_FFFF, 32'h0, `SRC_RESP_SLVERR);
    $display("test override and unmapped done");
    // policy bits and prior state must come through each standby return
    override <= 1'h0;
    wr(`SRC_CTRL_OFS, 32'h4, `SRC_RESP_OKAY);
    do_reset(1'h1);
    rd(`SRC_STATUS_OFS, 32'h2, 32'h2, `SRC_RESP_OKAY);
    wr(`SRC_CTRL_OFS, 32'h0, `SRC_RESP_OKAY);
    do_reset(1'h1);
    wr(`SRC_CTRL_OFS, 32'h2, `SRC_RESP_OKAY);
    do_reset(1'h0);
    wr(`SRC_CTRL_OFS, 32'h4, `SRC_RESP_OKAY);
    do_reset(1'h1);
    wr(`SRC_CTRL_OFS, 32'h0, `SRC_RESP_OKAY);
    override <= 1'h1;
    do_reset(1'h0);
    override <= 1'h0;
    wr(`SRC_CTRL_OFS, 32'h4, `SRC_RESP_OKAY);
    do_reset(1'h1);
    wr(`SRC_SLEEP_OFS, 32'h80, `SRC_RESP_OKAY);
    chk({31'h0, supply_oe}, 32'h0, "software power off");
    $display("test standby policy done");
    close_out();
  end
endmodule : standby_power_restore_control_test
